/* File: design/edc_axil_slave.sv */
// AXI4-Lite slave front end: one write and one read in flight.
// Assumes the register side answers decode and read data combinationally.
`timescale 1ns/100ps
module edc_axil_slave import edc_pkg::*; (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // Write address and data
    input wire logic [31:0] awaddr_in,
    input wire logic awvalid_in,
    output logic awready_out,
    input wire logic [31:0] wdata_in,
    input wire logic [3:0] wstrb_in,
    input wire logic wvalid_in,
    output logic wready_out,
    // Write response
    output logic [1:0] bresp_out,
    output logic bvalid_out,
    input wire logic bready_in,
    // Read
    input wire logic [31:0] araddr_in,
    input wire logic arvalid_in,
    output logic arready_out,
    output logic [31:0] rdata_out,
    output logic [1:0] rresp_out,
    output logic rvalid_out,
    input wire logic rready_in,
    // Register side
    edc_reg_if.slave regs
);
    logic aw_q, w_q, bvalid_q, rvalid_q;
    logic [31:0] awaddr_q, wdata_q, rdata_q;
    logic [3:0] wstrb_q;
    logic [1:0] bresp_q, rresp_q;

    assign awready_out = !aw_q && !bvalid_q;
    assign wready_out = !w_q && !bvalid_q;
    assign arready_out = !rvalid_q;
    wire aw_take = awvalid_in && awready_out;
    wire w_take = wvalid_in && wready_out;
    wire ar_take = arvalid_in && arready_out;
    wire wr_fire = (aw_q || aw_take) && (w_q || w_take);

    assign regs.wr_en = wr_fire;
    assign regs.wr_addr = aw_q ? awaddr_q : awaddr_in;
    assign regs.wr_data = w_q ? wdata_q : wdata_in;
    assign regs.wr_strb = w_q ? wstrb_q : wstrb_in;
    assign regs.rd_addr = araddr_in;
    assign bvalid_out = bvalid_q;
    assign bresp_out = bresp_q;
    assign rvalid_out = rvalid_q;
    assign rdata_out = rdata_q;
    assign rresp_out = rresp_q;

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            aw_q <= 1'b0;
            w_q <= 1'b0;
            awaddr_q <= 32'h0;
            wdata_q <= 32'h0;
            wstrb_q <= 4'h0;
        end else begin
            aw_q <= !wr_fire && (aw_q || aw_take);
            w_q <= !wr_fire && (w_q || w_take);
            if (aw_take) begin
                awaddr_q <= awaddr_in;
            end
            if (w_take) begin
                wdata_q <= wdata_in;
                wstrb_q <= wstrb_in;
            end
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_q <= 1'b1;
            bresp_q <= regs.wr_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (bready_in) begin
            bvalid_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0;
            rresp_q <= RESP_OKAY;
        end else if (ar_take) begin
            rvalid_q <= 1'b1;
            rdata_q <= regs.rd_ok ? regs.rd_data : 32'h0;
            rresp_q <= regs.rd_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (rready_in) begin
            rvalid_q <= 1'b0;
        end
    end
endmodule // edc_axil_slave

/* File: design/edc_edge_unit.sv */
// One edge input: source select, polarity and edge or level sensing.
// Assumes sources are synchronous to the block clock.
`timescale 1ns/100ps
module edc_edge_unit import edc_pkg::*; (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // Edge configuration and result
    edc_edge_if.unit bus
);
    logic prev_q;
    wire cur = (bus.sel == SRC_RESERVED) ? 1'b0 : bus.src[bus.sel];
    wire act = bus.pol ? cur : !cur;
    wire was = bus.pol ? prev_q : !prev_q;
    assign bus.hit = (bus.sel != SRC_RESERVED) && act && (!bus.mode || !was);

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            prev_q <= 1'b0;
        end else begin
            prev_q <= cur;
        end
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    property p_rise_hit;
        bus.mode && bus.pol && $stable(bus.sel) && $rose(cur) |-> bus.hit;
    endproperty
    a_rise_hit: assert property (p_rise_hit) else $error("Rising edge not reported");

    property p_edge_once;
        bus.mode && $stable(bus.sel) && $stable(bus.pol) && $stable(cur) |-> !bus.hit;
    endproperty
    a_edge_once: assert property (p_edge_once) else $error("Edge mode reported a steady input");

    property p_level_hit;
        !bus.mode && bus.sel != SRC_RESERVED && (cur == bus.pol) |-> bus.hit;
    endproperty
    a_level_hit: assert property (p_level_hit) else $error("Active level not reported");

    property p_reserved;
        bus.sel == SRC_RESERVED |-> !bus.hit;
    endproperty
    a_reserved: assert property (p_reserved) else $error("Reserved source produced an edge");
endmodule // edc_edge_unit

/* File: design/edc_ifs.sv */
// Carriers between the top of the edge delay block and its leaves.
// Assumes all members share the single block clock.
`timescale 1ns/100ps
interface edc_edge_if;
    import edc_pkg::*;
    logic [NUM_SRC-1:0] src;
    edc_src_t sel;
    logic pol;
    logic mode;
    logic hit;
    modport unit (input src, input sel, input pol, input mode, output hit);
    modport ctrl (output src, output sel, output pol, output mode, input hit);
endinterface

interface edc_reg_if;
    logic wr_en;
    logic [31:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic wr_ok;
    logic [31:0] rd_addr;
    logic [31:0] rd_data;
    logic rd_ok;
    modport slave (output wr_en, output wr_addr, output wr_data, output wr_strb, input wr_ok,
                   output rd_addr, input rd_data, input rd_ok);
    modport regs (input wr_en, input wr_addr, input wr_data, input wr_strb, output wr_ok,
                  input rd_addr, output rd_data, output rd_ok);
endinterface

/* File: design/edc_pkg.sv */
// Shared constants for the edge delay control block.
// Assumes a 32-bit AXI4-Lite register bus and 15 selectable edge sources plus one reserved source code.
package edc_pkg;
    // Register byte offsets
    localparam logic [31:0] OFS_CTRL = 32'h0000_0000;
    localparam logic [31:0] OFS_AUX = 32'h0000_0004;
    localparam logic [31:0] OFS_IRQ_STAT = 32'h0000_0008;
    localparam logic [31:0] OFS_IRQ_MASK = 32'h0000_000c;
    // Control register fields
    localparam int B_FIRST_FLAG = 24;
    localparam int B_SENSE = 23;
    localparam int B_POL = 22;
    localparam int B_SRC_HI = 21;
    localparam int B_SRC_LO = 18;
    localparam int B_ON = 15;
    localparam int B_HALT = 13;
    localparam int B_DGEN = 12;
    localparam int B_GATE = 11;
    localparam int B_ORDER = 10;
    localparam logic [31:0] CTRL_WMASK = 32'h00fc_bc00;
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    // Auxiliary register fields
    localparam int A_SRC_HI = 3;
    localparam int A_SRC_LO = 0;
    localparam int A_POL = 4;
    localparam int A_SENSE = 5;
    localparam int A_DISCH = 8;
    localparam int A_SECOND_FLAG = 16;
    localparam logic [31:0] AUX_WMASK = 32'h0000_013f;
    localparam logic [31:0] AUX_RST = 32'h0000_0000;
    // Interrupt bits
    localparam int I_FIRST = 0;
    localparam int I_SECOND = 1;
    localparam int NUM_IRQ = 2;
    localparam logic [NUM_IRQ-1:0] IRQ_RST = 2'h0;
    // Edge source codes
    localparam int NUM_SRC = 16;
    localparam int SRC_TIMER = 0;
    localparam int SRC_CMP_ONE = 1;
    localparam int SRC_EXT_TWO = 2;
    localparam int SRC_EXT_ONE = 3;
    localparam int SRC_OCMP_LO = 4;
    localparam int SRC_OCMP_HI = 6;
    localparam int SRC_ICAP_LO = 7;
    localparam int SRC_ICAP_HI = 11;
    localparam int SRC_PCLK = 12;
    localparam int SRC_COMP_ONE = 13;
    localparam int SRC_COMP_TWO = 14;
    localparam logic [3:0] SRC_RESERVED = 4'hf;
    // Bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef logic [3:0] edc_src_t;
endpackage

/* File: design/edc_top.sv */
// Edge delay control: two conditioned edge inputs, status flags and delay pulse.
// Assumes event sources are synchronous one-clock signals and an AXI4-Lite master.
`timescale 1ns/100ps
module edc_top import edc_pkg::*; (
    // Clock and reset
    input wire logic MCLK_IN,
    input wire logic RST_N_IN,
    // AXI4-Lite write
    input wire logic [31:0] AXI_AWADDR_IN,
    input wire logic AXI_AWVALID_IN,
    output logic AXI_AWREADY_OUT,
    input wire logic [31:0] AXI_WDATA_IN,
    input wire logic [3:0] AXI_WSTRB_IN,
    input wire logic AXI_WVALID_IN,
    output logic AXI_WREADY_OUT,
    output logic [1:0] AXI_BRESP_OUT,
    output logic AXI_BVALID_OUT,
    input wire logic AXI_BREADY_IN,
    // AXI4-Lite read
    input wire logic [31:0] AXI_ARADDR_IN,
    input wire logic AXI_ARVALID_IN,
    output logic AXI_ARREADY_OUT,
    output logic [31:0] AXI_RDATA_OUT,
    output logic [1:0] AXI_RRESP_OUT,
    output logic AXI_RVALID_OUT,
    input wire logic AXI_RREADY_IN,
    // Edge sources
    input wire logic TIMER_EVT_IN,
    input wire logic COMPARE_ONE_EVT_IN,
    input wire logic EXTERNAL_EDGE_PIN_ONE_IN,
    input wire logic EXTERNAL_EDGE_PIN_TWO_IN,
    input wire logic [2:0] OUT_COMPARE_EVT_IN,
    input wire logic [4:0] IN_CAPTURE_EVT_IN,
    input wire logic PERIPHERAL_CLOCK_THREE_IN,
    input wire logic COMPARATOR_ONE_OUTPUT_IN,
    input wire logic COMPARATOR_TWO_OUTPUT_IN,
    // Power state
    input wire logic CHIP_IDLE_IN,
    // Results
    output logic DELAY_PULSE_OUT,
    output logic CHARGE_ACTIVE_OUT,
    output logic SAMPLER_DISCHARGE_OUT,
    output logic IRQ_OUT
);
    logic [31:0] ctrl_q, aux_q;
    logic first_q, second_q, pulse_q, charge_q, disch_q;
    logic [NUM_IRQ-1:0] stat_q, mask_q;
    logic [NUM_SRC-1:0] src_vec;
    logic [1:0] hit_w;
    edc_src_t sel_w [2];
    logic pol_w [2];
    logic mode_w [2];

    edc_reg_if regs();

    edc_axil_slave u_slave (
        .clk_in(MCLK_IN),
        .rst_n_in(RST_N_IN),
        .awaddr_in(AXI_AWADDR_IN),
        .awvalid_in(AXI_AWVALID_IN),
        .awready_out(AXI_AWREADY_OUT),
        .wdata_in(AXI_WDATA_IN),
        .wstrb_in(AXI_WSTRB_IN),
        .wvalid_in(AXI_WVALID_IN),
        .wready_out(AXI_WREADY_OUT),
        .bresp_out(AXI_BRESP_OUT),
        .bvalid_out(AXI_BVALID_OUT),
        .bready_in(AXI_BREADY_IN),
        .araddr_in(AXI_ARADDR_IN),
        .arvalid_in(AXI_ARVALID_IN),
        .arready_out(AXI_ARREADY_OUT),
        .rdata_out(AXI_RDATA_OUT),
        .rresp_out(AXI_RRESP_OUT),
        .rvalid_out(AXI_RVALID_OUT),
        .rready_in(AXI_RREADY_IN),
        .regs(regs.slave)
    );

    // Source code map
    assign src_vec[SRC_TIMER] = TIMER_EVT_IN;
    assign src_vec[SRC_CMP_ONE] = COMPARE_ONE_EVT_IN;
    assign src_vec[SRC_EXT_TWO] = EXTERNAL_EDGE_PIN_TWO_IN;
    assign src_vec[SRC_EXT_ONE] = EXTERNAL_EDGE_PIN_ONE_IN;
    assign src_vec[SRC_OCMP_HI:SRC_OCMP_LO] = OUT_COMPARE_EVT_IN;
    assign src_vec[SRC_ICAP_HI:SRC_ICAP_LO] = IN_CAPTURE_EVT_IN;
    assign src_vec[SRC_PCLK] = PERIPHERAL_CLOCK_THREE_IN;
    assign src_vec[SRC_COMP_ONE] = COMPARATOR_ONE_OUTPUT_IN;
    assign src_vec[SRC_COMP_TWO] = COMPARATOR_TWO_OUTPUT_IN;
    assign src_vec[SRC_RESERVED] = 1'b0;

    // Edge configuration: index 0 first edge, index 1 second edge
    assign sel_w[0] = aux_q[A_SRC_HI:A_SRC_LO];
    assign pol_w[0] = aux_q[A_POL];
    assign mode_w[0] = aux_q[A_SENSE];
    assign sel_w[1] = ctrl_q[B_SRC_HI:B_SRC_LO];
    assign pol_w[1] = ctrl_q[B_POL];
    assign mode_w[1] = ctrl_q[B_SENSE];

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_edge
            edc_edge_if eif();
            assign eif.src = src_vec;
            assign eif.sel = sel_w[g];
            assign eif.pol = pol_w[g];
            assign eif.mode = mode_w[g];
            assign hit_w[g] = eif.hit;
            edc_edge_unit u_unit (
                .clk_in(MCLK_IN),
                .rst_n_in(RST_N_IN),
                .bus(eif.unit)
            );
        end
    endgenerate

    // Address decode and byte lanes
    wire wr_ctrl = regs.wr_en && (regs.wr_addr[31:2] == OFS_CTRL[31:2]);
    wire wr_aux = regs.wr_en && (regs.wr_addr[31:2] == OFS_AUX[31:2]);
    wire wr_stat = regs.wr_en && (regs.wr_addr[31:2] == OFS_IRQ_STAT[31:2]);
    wire wr_mask = regs.wr_en && (regs.wr_addr[31:2] == OFS_IRQ_MASK[31:2]);
    assign regs.wr_ok = regs.wr_addr[31:4] == OFS_CTRL[31:4];
    assign regs.rd_ok = regs.rd_addr[31:4] == OFS_CTRL[31:4];
    wire [31:0] lane = {{8{regs.wr_strb[3]}}, {8{regs.wr_strb[2]}}, {8{regs.wr_strb[1]}}, {8{regs.wr_strb[0]}}};
    wire [31:0] ctrl_d = (ctrl_q & ~(lane & CTRL_WMASK)) | (regs.wr_data & lane & CTRL_WMASK);
    wire [31:0] aux_d = (aux_q & ~(lane & AUX_WMASK)) | (regs.wr_data & lane & AUX_WMASK);
    wire sw_first = wr_ctrl && lane[B_FIRST_FLAG];
    wire sw_second = wr_aux && lane[A_SECOND_FLAG];

    // Edge qualification
    wire on = ctrl_q[B_ON];
    wire halt = ctrl_q[B_HALT];
    wire gate = ctrl_q[B_GATE];
    wire order = ctrl_q[B_ORDER];
    wire dgen = ctrl_q[B_DGEN];
    wire active = on && !(halt && CHIP_IDLE_IN);
    wire ev_ok = active && gate;
    wire set1 = ev_ok && hit_w[0];
    wire set2 = ev_ok && hit_w[1] && (!order || first_q);
    wire [NUM_IRQ-1:0] ev = {set2 && !second_q, set1 && !first_q};
    wire [NUM_IRQ-1:0] w1c = wr_stat ? (regs.wr_data[NUM_IRQ-1:0] & {NUM_IRQ{regs.wr_strb[0]}}) : IRQ_RST;

    always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            ctrl_q <= CTRL_RST;
            aux_q <= AUX_RST;
            mask_q <= IRQ_RST;
            stat_q <= IRQ_RST;
        end else begin
            ctrl_q <= wr_ctrl ? ctrl_d : ctrl_q;
            aux_q <= wr_aux ? aux_d : aux_q;
            mask_q <= (wr_mask && regs.wr_strb[0]) ? regs.wr_data[NUM_IRQ-1:0] : mask_q;
            stat_q <= (stat_q & ~w1c) | ev;
        end
    end

    // Edge flags: a hardware edge wins over a software clear
    always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            first_q <= 1'b0;
            second_q <= 1'b0;
        end else begin
            first_q <= set1 || (sw_first ? regs.wr_data[B_FIRST_FLAG] : first_q);
            second_q <= set2 || (sw_second ? regs.wr_data[A_SECOND_FLAG] : second_q);
        end
    end

    // Delay pulse, charge window and discharge drive
    always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            pulse_q <= 1'b0;
            charge_q <= 1'b0;
            disch_q <= 1'b0;
        end else begin
            pulse_q <= dgen && active && first_q && !second_q;
            charge_q <= active && (first_q ^ second_q);
            disch_q <= on && aux_q[A_DISCH];
        end
    end

    assign DELAY_PULSE_OUT = pulse_q;
    assign CHARGE_ACTIVE_OUT = charge_q;
    assign SAMPLER_DISCHARGE_OUT = disch_q;
    assign IRQ_OUT = |(stat_q & mask_q);

    // Read mux
    wire [31:0] ctrl_rd = ctrl_q | ({31'h0, first_q} << B_FIRST_FLAG);
    wire [31:0] aux_rd = aux_q | ({31'h0, second_q} << A_SECOND_FLAG);
    wire [31:0] stat_rd = {{(32-NUM_IRQ){1'b0}}, stat_q};
    wire [31:0] mask_rd = {{(32-NUM_IRQ){1'b0}}, mask_q};
    wire [1:0] rd_idx = regs.rd_addr[3:2];
    assign regs.rd_data = (rd_idx == OFS_CTRL[3:2]) ? ctrl_rd :
                          (rd_idx == OFS_AUX[3:2]) ? aux_rd :
                          (rd_idx == OFS_IRQ_STAT[3:2]) ? stat_rd : mask_rd;

    // Checks
    default clocking cb @(posedge MCLK_IN); endclocking
    default disable iff (!RST_N_IN);
    wire no_sw = !sw_first && !sw_second;

    property p_first_set;
        active && gate && hit_w[0] |=> first_q;
    endproperty
    a_first_set: assert property (p_first_set) else $error("First edge not recorded");

    property p_off_hold;
        !on && no_sw |=> $stable(first_q) && $stable(second_q);
    endproperty
    a_off_hold: assert property (p_off_hold) else $error("Flags moved while disabled");

    property p_idle_hold;
        halt && CHIP_IDLE_IN && no_sw |=> $stable(first_q) && $stable(second_q);
    endproperty
    a_idle_hold: assert property (p_idle_hold) else $error("Flags moved while halted in idle");

    property p_gate_block;
        !gate && no_sw |=> $stable(first_q) && $stable(second_q);
    endproperty
    a_gate_block: assert property (p_gate_block) else $error("Edge passed a closed gate");

    property p_order;
        order && !first_q && !second_q && !sw_second |=> !second_q;
    endproperty
    a_order: assert property (p_order) else $error("Second edge accepted before first");

    property p_dgen_off;
        !dgen |=> !DELAY_PULSE_OUT;
    endproperty
    a_dgen_off: assert property (p_dgen_off) else $error("Delay pulse while generation off");

    property p_pulse_window;
        dgen && active && first_q && !second_q |=> DELAY_PULSE_OUT;
    endproperty
    a_pulse_window: assert property (p_pulse_window) else $error("Delay pulse missing in edge window");

    property p_irq_raise;
        set1 && !first_q && mask_q[I_FIRST] && !wr_mask && !wr_stat |=> IRQ_OUT;
    endproperty
    a_irq_raise: assert property (p_irq_raise) else $error("Interrupt not raised on first edge");
endmodule // edc_top

/* File: sim/edc_src_model.sv */
// Event source model: turns requested levels into clocked source signals.
// Assumes the bench drives lvl_in right after rising clock edges.
`timescale 1ns/100ps
module edc_src_model (
    // Clock
    input wire logic clk_in,
    // Requested level per source code
    input wire logic [15:0] lvl_in,
    // Source signal per code
    output logic [15:0] src_out
);
    initial begin
        src_out = 16'h0000;
    end
    // Code 15 has no source behind it
    always @(posedge clk_in) begin
        src_out <= lvl_in & 16'h7fff;
    end
endmodule // edc_src_model

/* File: sim/edge_delay_control_tb.sv */
// Bench for the edge delay block: register tasks, event pulses, checks.
// Assumes edc_top as the device and edc_src_model as the event sources.
`timescale 1ns/100ps
module edge_delay_control_tb import edc_pkg::*;;
    localparam logic [31:0] ON = 32'h1 << B_ON;
    localparam logic [31:0] G = 32'h1 << B_GATE;
    localparam logic [31:0] ORD = 32'h1 << B_ORDER;
    localparam logic [31:0] HLT = 32'h1 << B_HALT;
    localparam logic [31:0] DG = 32'h1 << B_DGEN;
    localparam logic [31:0] SN = 32'h1 << B_SENSE;
    localparam logic [31:0] PL = 32'h1 << B_POL;
    localparam logic [31:0] FF = 32'h1 << B_FIRST_FLAG;
    localparam logic [31:0] AP = 32'h1 << A_POL;
    localparam logic [31:0] DIS = 32'h1 << A_DISCH;
    localparam logic [31:0] SF = 32'h1 << A_SECOND_FLAG;
    logic clk = 1'b0;
    logic rst_n, awv, wv, bre, arv, rre, idle, awr, wrd, bv, arr, rv, dly, chg, dis, irq;
    logic [31:0] awa, wd, ara, rdt, d;
    logic [1:0] br, rr, r;
    logic [15:0] lvl, src;
    int error_cnt = 0;
    int cmp_count = 0;
    int cyc = 0;
    always #25 clk = ~clk;
    edc_src_model edc_src_model_inst (.clk_in(clk), .lvl_in(lvl), .src_out(src));
    edc_top edc_top_inst (
        .MCLK_IN(clk), .RST_N_IN(rst_n),
        .AXI_AWADDR_IN(awa), .AXI_AWVALID_IN(awv), .AXI_AWREADY_OUT(awr),
        .AXI_WDATA_IN(wd), .AXI_WSTRB_IN(4'hf), .AXI_WVALID_IN(wv), .AXI_WREADY_OUT(wrd),
        .AXI_BRESP_OUT(br), .AXI_BVALID_OUT(bv), .AXI_BREADY_IN(bre),
        .AXI_ARADDR_IN(ara), .AXI_ARVALID_IN(arv), .AXI_ARREADY_OUT(arr),
        .AXI_RDATA_OUT(rdt), .AXI_RRESP_OUT(rr), .AXI_RVALID_OUT(rv), .AXI_RREADY_IN(rre),
        .TIMER_EVT_IN(src[0]), .COMPARE_ONE_EVT_IN(src[1]),
        .EXTERNAL_EDGE_PIN_TWO_IN(src[2]), .EXTERNAL_EDGE_PIN_ONE_IN(src[3]),
        .OUT_COMPARE_EVT_IN(src[6:4]), .IN_CAPTURE_EVT_IN(src[11:7]),
        .PERIPHERAL_CLOCK_THREE_IN(src[12]), .COMPARATOR_ONE_OUTPUT_IN(src[13]),
        .COMPARATOR_TWO_OUTPUT_IN(src[14]), .CHIP_IDLE_IN(idle),
        .DELAY_PULSE_OUT(dly), .CHARGE_ACTIVE_OUT(chg), .SAMPLER_DISCHARGE_OUT(dis), .IRQ_OUT(irq));
    task automatic wrap_up();
        $display("counts: %0d compares, %0d mismatches", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            wrap_up();
        end
    end
    task automatic chk32(input string n, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            error_cnt++;
            $display("unexpected %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic chk1(input string n, input logic e, input logic g);
        cmp_count++;
        if (g !== e) begin
            error_cnt++;
            $display("unexpected %s expected %b seen %b", n, e, g);
        end
    endtask
    task automatic axw(input logic [31:0] a, input logic [31:0] v, output logic [1:0] rs);
        logic ah, wh, ad, wdn, h;
        ad = 1'b0;
        wdn = 1'b0;
        @(posedge clk);
        awa <= a;
        awv <= 1'b1;
        wd <= v;
        wv <= 1'b1;
        bre <= 1'b1;
        while (!(ad && wdn)) begin
            @(negedge clk);
            ah = !ad && awr;
            wh = !wdn && wrd;
            @(posedge clk);
            if (ah) begin
                awv <= 1'b0;
                ad = 1'b1;
            end
            if (wh) begin
                wv <= 1'b0;
                wdn = 1'b1;
            end
        end
        do begin
            @(negedge clk);
            h = bv;
            rs = br;
            @(posedge clk);
        end while (!h);
        bre <= 1'b0;
    endtask
    task automatic axr(input logic [31:0] a, output logic [31:0] v, output logic [1:0] rs);
        logic h;
        @(posedge clk);
        ara <= a;
        arv <= 1'b1;
        rre <= 1'b1;
        do begin
            @(negedge clk);
            h = arr;
            @(posedge clk);
        end while (!h);
        arv <= 1'b0;
        do begin
            @(negedge clk);
            h = rv;
            v = rdt;
            rs = rr;
            @(posedge clk);
        end while (!h);
        rre <= 1'b0;
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] v);
        axw(a, v, r);
        chk32("bresp", {30'h0, RESP_OKAY}, {30'h0, r});
    endtask
    task automatic rdc(input string n, input logic [31:0] a, input logic [31:0] e);
        axr(a, d, r);
        chk32("rresp", {30'h0, RESP_OKAY}, {30'h0, r});
        chk32(n, e, d);
    endtask
    task automatic pulse(input logic [15:0] v);
        @(posedge clk);
        lvl <= v;
        @(posedge clk);
        lvl <= 16'h0000;
        repeat (4) @(posedge clk);
    endtask
    task automatic settle();
        repeat (3) @(posedge clk);
        @(negedge clk);
    endtask
    task automatic done(input string n);
        $display("test %s finished", n);
    endtask
    initial begin
        {awv, wv, bre, arv, rre, idle, rst_n} = 7'h00;
        {awa, wd, ara} = 96'h0;
        lvl = 16'h0000;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        rdc("ctrl reset", OFS_CTRL, CTRL_RST);
        rdc("aux reset", OFS_AUX, AUX_RST);
        rdc("status reset", OFS_IRQ_STAT, 32'h0);
        rdc("mask reset", OFS_IRQ_MASK, 32'h0);
        axr(32'h10, d, r);
        chk32("unmapped rresp", {30'h0, RESP_SLVERR}, {30'h0, r});
        chk32("unmapped rdata", 32'h0, d);
        axw(32'h10, 32'hffffffff, r);
        chk32("unmapped bresp", {30'h0, RESP_SLVERR}, {30'h0, r});
        wr(OFS_AUX, 32'hffffffff);
        rdc("aux bits", OFS_AUX, AUX_WMASK | SF);
        wr(OFS_AUX, AP);
        wr(OFS_CTRL, 32'hffffffff);
        rdc("ctrl bits", OFS_CTRL, CTRL_WMASK | FF);
        wr(OFS_CTRL, G | PL);
        wr(OFS_AUX, AP);
        wr(OFS_IRQ_STAT, 32'h3);
        rdc("status cleared", OFS_IRQ_STAT, 32'h0);
        done("registers");
        pulse(16'h0003);
        rdc("ctrl while off", OFS_CTRL, G | PL);
        rdc("aux while off", OFS_AUX, AP);
        wr(OFS_CTRL, ON | PL);
        pulse(16'h0001);
        rdc("ctrl gated", OFS_CTRL, ON | PL);
        wr(OFS_CTRL, ON | G | PL);
        pulse(16'h0001);
        rdc("first flag", OFS_CTRL, ON | G | PL | FF);
        rdc("status both edges", OFS_IRQ_STAT, 32'h3);
        chk1("irq masked", 1'b0, irq);
        wr(OFS_IRQ_MASK, 32'h1);
        settle();
        chk1("irq unmasked", 1'b1, irq);
        wr(OFS_IRQ_STAT, 32'h2);
        rdc("status kept", OFS_IRQ_STAT, 32'h1);
        wr(OFS_IRQ_STAT, 32'h1);
        settle();
        chk1("irq cleared", 1'b0, irq);
        done("gate and flag");
        wr(OFS_CTRL, ON | G | PL | HLT);
        @(posedge clk);
        idle <= 1'b1;
        pulse(16'h0001);
        rdc("halted", OFS_CTRL, ON | G | PL | HLT);
        wr(OFS_CTRL, ON | G | PL);
        pulse(16'h0001);
        rdc("idle running", OFS_CTRL, ON | G | PL | FF);
        @(posedge clk);
        idle <= 1'b0;
        done("idle");
        wr(OFS_CTRL, ON | G | PL | ORD | (32'h1 << B_SRC_LO));
        wr(OFS_AUX, AP);
        pulse(16'h0002);
        rdc("second early", OFS_AUX, AP);
        pulse(16'h0001);
        pulse(16'h0002);
        rdc("second after", OFS_AUX, AP | SF);
        rdc("status both", OFS_IRQ_STAT, 32'h3);
        done("order");
        for (int c = 0; c < 15; c++) begin
            wr(OFS_CTRL, ON | G | PL | (32'(c) << B_SRC_LO));
            wr(OFS_AUX, AP);
            pulse(16'h1 << ((c + 1) % 15));
            rdc("other source", OFS_AUX, AP);
            pulse(16'h1 << c);
            rdc("chosen source", OFS_AUX, AP | SF);
        end
        wr(OFS_CTRL, ON | G | PL | (32'hf << B_SRC_LO));
        wr(OFS_AUX, AP);
        pulse(16'hffff);
        rdc("reserved source", OFS_AUX, AP);
        done("sources");
        wr(OFS_CTRL, ON | G | SN | (32'h2 << B_SRC_LO));
        @(posedge clk);
        lvl <= 16'h0004;
        wr(OFS_AUX, AP);
        rdc("rise in fall mode", OFS_AUX, AP);
        @(posedge clk);
        lvl <= 16'h0000;
        // Let the falling edge reach the flag before the read is taken
        @(posedge clk);
        rdc("fall in fall mode", OFS_AUX, AP | SF);
        wr(OFS_CTRL, ON | G | PL | SN | (32'h2 << B_SRC_LO));
        @(posedge clk);
        lvl <= 16'h0004;
        repeat (4) @(posedge clk);
        wr(OFS_AUX, AP);
        rdc("held high edge", OFS_AUX, AP);
        wr(OFS_CTRL, ON | G | PL | (32'h2 << B_SRC_LO));
        rdc("held high level", OFS_AUX, AP | SF);
        @(posedge clk);
        lvl <= 16'h0000;
        done("sensing");
        wr(OFS_AUX, AP);
        wr(OFS_CTRL, ON | G | PL | DG | FF | (32'he << B_SRC_LO));
        settle();
        chk1("delay open", 1'b1, dly);
        chk1("charge open", 1'b1, chg);
        pulse(16'h4000);
        settle();
        chk1("delay closed", 1'b0, dly);
        chk1("charge closed", 1'b0, chg);
        wr(OFS_AUX, AP);
        wr(OFS_CTRL, ON | G | PL | FF | (32'he << B_SRC_LO));
        settle();
        chk1("delay off", 1'b0, dly);
        wr(OFS_AUX, AP | DIS);
        settle();
        chk1("discharge on", 1'b1, dis);
        wr(OFS_CTRL, 32'h0);
        settle();
        chk1("discharge off", 1'b0, dis);
        done("delay and discharge");
        wrap_up();
    end
endmodule // edge_delay_control_tb
